// >>> logic/rcb_pkg.sv
// Purpose: Constants and carriers for the switch capability and CSR bank.
// Assumes: Maintenance and I2C accesses arrive already decoded into words.
// Notes:   Capability bit positions live here; the bank assembles the words.
// How it works
// - Feature word reads ones at bits 8, 9, 10: route config and multicast.
// - Feature word: bit 28 switch set; bits 29, 30, 31 read zero.
// - Port info low byte returns arrival port, or 0xFE over I2C.
// - Port info bits 15:8 report the variant's port total.
// - Source operations word reads one only at bit 2, port-write.
// - Source operation bits 4 to 15 all read zero.
// - Multicast support word reads zero, basic group model absent.
// - Route table limit reads 0xFF in bits 15:0, 256 IDs.
// - Multicast info: ten masks, 0xFF IDs per mask, association bits zero.
// - Initializer ID is 16-bit read/write, reset to all ones.
// - Route selector holds target ID, wide ID high byte, extended enable bit 31.
// - Route port word holds four egress bytes for ID and next three IDs.
// - Default output port is read/write in bits 7:0, reset zero.
// - Group edit write decodes bits 6:4 as verify, add, delete, delete all, add all.
// - Group edit acts on egress port 15:8 and mask number 31:16.
// - Verify sets bit 0 when the port is enabled in the mask.
// - Link selector holds mask 15:0, ID 23:16, wide ID byte 31:24.
// - Link operation write runs command 6:5 with transport choice in bit 7.
// - Link operation bit 0 reports whether the last verified link exists.
// - Maintenance block header reads ID 0x0009 and zero next pointer.
// - Link timeout value is read/write in bits 31:8, reset all ones.
// - Component label is a 32-bit read/write register.
package rcb_pkg;
   // Register byte addresses
   localparam logic [23:0] OFS_FEATURE   = 24'h000010;
   localparam logic [23:0] OFS_PORT_INFO = 24'h000014;
   localparam logic [23:0] OFS_SRC_OPS   = 24'h000018;
   localparam logic [23:0] OFS_MC_SUP    = 24'h000030;
   localparam logic [23:0] OFS_RT_LIMIT  = 24'h000034;
   localparam logic [23:0] OFS_MC_INFO   = 24'h000038;
   localparam logic [23:0] OFS_HOST_ID   = 24'h000068;
   localparam logic [23:0] OFS_LABEL     = 24'h00006C;
   localparam logic [23:0] OFS_RT_SEL    = 24'h000070;
   localparam logic [23:0] OFS_RT_PORT   = 24'h000074;
   localparam logic [23:0] OFS_RT_DEF    = 24'h000078;
   localparam logic [23:0] OFS_GRP_EDIT  = 24'h000080;
   localparam logic [23:0] OFS_LNK_SEL   = 24'h000084;
   localparam logic [23:0] OFS_LNK_OP    = 24'h000088;
   localparam logic [23:0] OFS_BLK_HEAD  = 24'h000100;
   localparam logic [23:0] OFS_TIMEOUT   = 24'h000120;
   localparam logic [23:0] OFS_GEN_CTRL  = 24'h00013C;
   // Fixed capability words
   localparam logic [31:0] FEATURE_LOW   = 32'h00000059;
   localparam int unsigned FEAT_STD_RT   = 8;
   localparam int unsigned FEAT_EXT_RT   = 9;
   localparam int unsigned FEAT_MCAST    = 10;
   localparam int unsigned FEAT_SWITCH   = 28;
   localparam int unsigned SRC_PORT_WR   = 2;
   localparam logic [31:0] MC_SUP_VALUE  = 32'h00000000;
   localparam logic [15:0] RT_LIMIT_VAL  = 16'h00FF;
   localparam logic [15:0] MC_MASK_CNT   = 16'h000A;
   localparam logic [13:0] MC_IDS_PER    = 14'h00FF;
   localparam logic [15:0] BLK_FEAT_ID   = 16'h0009;
   localparam logic [15:0] BLK_NEXT_PTR  = 16'h0000;
   localparam logic [7:0]  I2C_PORT_CODE = 8'hFE;
   // Reset values
   localparam logic [15:0] HOST_ID_RST   = 16'hFFFF;
   localparam logic [23:0] TIMEOUT_RST   = 24'hFFFFFF;
   localparam logic [31:0] WORD_RST      = 32'h00000000;
   // Storage sizes
   localparam int unsigned GROUPS        = 10;
   localparam int unsigned PORTS         = 16;
   localparam int unsigned IDS           = 256;
   // Field positions
   localparam int unsigned EXT_EN_BIT    = 31;
   localparam int unsigned TO_LSB        = 8;
   localparam int unsigned CMD_LSB       = 4;
   localparam int unsigned LNK_CMD_LSB   = 5;
   localparam int unsigned LNK_WIDE_BIT  = 7;
   // Group edit commands
   localparam logic [2:0]  GRP_VERIFY    = 3'h0;
   localparam logic [2:0]  GRP_ADD       = 3'h1;
   localparam logic [2:0]  GRP_DEL       = 3'h2;
   localparam logic [2:0]  GRP_DEL_ALL   = 3'h4;
   localparam logic [2:0]  GRP_ADD_ALL   = 3'h5;
   // Link commands
   localparam logic [1:0]  LNK_VERIFY    = 2'h0;
   localparam logic [1:0]  LNK_DEL       = 2'h1;
   localparam logic [1:0]  LNK_ADD       = 2'h3;

   // One maintenance access, from a switch port or from I2C
   typedef struct packed {
      logic        wr;
      logic [23:0] addr;
      logic [31:0] wdata;
      logic [7:0]  src_port;
      logic        via_i2c;
   } rcb_req_s;

   // Route entry programming toward the route tables
   typedef struct packed {
      logic        ext_en;
      logic [7:0]  wide_id_high;
      logic [7:0]  target_id;
      logic [31:0] egress;
   } rcb_route_s;
endpackage : rcb_pkg

// >>> logic/rcb_csr_bank.sv
// Purpose: Capability and command/status register bank of a packet switch.
// Assumes: One access per request pulse; all inputs on clk_i.
// Notes:   Answer comes one cycle after the request, for reads and writes.
`timescale 1ns/1ps
`default_nettype none
module rcb_csr_bank #(
   parameter logic [7:0] PORT_TOTAL = 8'h10
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     req_valid_i,
   input  wire rcb_pkg::rcb_req_s        req_i,
   output logic                          rsp_valid_o,
   output logic [31:0]                   rsp_data_o,
   output logic                          route_upd_o,
   output rcb_pkg::rcb_route_s           route_o,
   output logic [7:0]                    default_port_o,
   output logic [23:0]                   link_timeout_o,
   output logic [15:0]                   initializer_id_o,
   output logic [rcb_pkg::PORTS*rcb_pkg::GROUPS-1:0] group_ports_o
);

   // Register state
   logic [15:0] host_id_q,   host_id_d;
   logic [31:0] label_q,     label_d;
   logic [7:0]  sel_id_q,    sel_id_d;
   logic [7:0]  sel_hi_q,    sel_hi_d;
   logic        sel_ext_q,   sel_ext_d;
   logic [31:0] rt_port_q,   rt_port_d;
   logic [7:0]  def_port_q,  def_port_d;
   logic [2:0]  grp_cmd_q,   grp_cmd_d;
   logic [7:0]  grp_port_q,  grp_port_d;
   logic [15:0] grp_sel_q,   grp_sel_d;
   logic        grp_hit_q,   grp_hit_d;
   logic [31:0] lnk_sel_q,   lnk_sel_d;
   logic [1:0]  lnk_cmd_q,   lnk_cmd_d;
   logic        lnk_wide_q,  lnk_wide_d;
   logic        lnk_hit_q,   lnk_hit_d;
   logic [23:0] timeout_q,   timeout_d;
   logic        rsp_vld_q,   rsp_vld_d;
   logic [31:0] rsp_dat_q,   rsp_dat_d;
   logic        upd_q,       upd_d;

   // Group membership and ID-to-group links
   logic [rcb_pkg::PORTS-1:0]  grp_q [rcb_pkg::GROUPS];
   logic [rcb_pkg::PORTS-1:0]  grp_d [rcb_pkg::GROUPS];
   logic [rcb_pkg::GROUPS-1:0] lnk_q [rcb_pkg::IDS];
   logic [rcb_pkg::GROUPS-1:0] lnk_d [rcb_pkg::IDS];

   logic        wr_en;
   logic        rd_en;
   logic [31:0] wd;
   logic [3:0]  g_idx;
   logic        g_ok;
   logic        p_ok;
   logic [3:0]  l_idx;
   logic        l_ok;
   logic [7:0]  l_id;
   logic        l_id_ok;

   // Fixed capability words
   function automatic logic [31:0] feature_word();
      logic [31:0] w;
      w = rcb_pkg::FEATURE_LOW;
      w[rcb_pkg::FEAT_STD_RT] = 1'b1;
      w[rcb_pkg::FEAT_EXT_RT] = 1'b1;
      w[rcb_pkg::FEAT_MCAST]  = 1'b1;
      w[rcb_pkg::FEAT_SWITCH] = 1'b1;              // bits 31:29 stay zero
      return w;
   endfunction : feature_word

   function automatic logic [31:0] src_ops_word();
      logic [31:0] w;
      w = rcb_pkg::WORD_RST;
      w[rcb_pkg::SRC_PORT_WR] = 1'b1;
      return w;
   endfunction : src_ops_word

   assign wr_en = req_valid_i && req_i.wr;
   assign rd_en = req_valid_i && !req_i.wr;
   assign wd    = req_i.wdata;

   // Group edit target, from the incoming write word
   assign g_idx = wd[19:16];
   assign g_ok  = (wd[31:16] < 16'(rcb_pkg::GROUPS));
   assign p_ok  = (wd[15:8] < 8'(rcb_pkg::PORTS)) && (wd[15:8] < PORT_TOTAL);

   // Link target, from the stored selector
   assign l_idx   = lnk_sel_q[3:0];
   assign l_ok    = (lnk_sel_q[15:0] < 16'(rcb_pkg::GROUPS));
   assign l_id    = lnk_sel_q[23:16];
   assign l_id_ok = !wd[rcb_pkg::LNK_WIDE_BIT] || (lnk_sel_q[31:24] == 8'h00);

   // Writable registers and command side effects
   always_comb begin
      host_id_d  = host_id_q;
      label_d    = label_q;
      sel_id_d   = sel_id_q;
      sel_hi_d   = sel_hi_q;
      sel_ext_d  = sel_ext_q;
      rt_port_d  = rt_port_q;
      def_port_d = def_port_q;
      grp_cmd_d  = grp_cmd_q;
      grp_port_d = grp_port_q;
      grp_sel_d  = grp_sel_q;
      grp_hit_d  = grp_hit_q;
      lnk_sel_d  = lnk_sel_q;
      lnk_cmd_d  = lnk_cmd_q;
      lnk_wide_d = lnk_wide_q;
      lnk_hit_d  = lnk_hit_q;
      timeout_d  = timeout_q;
      upd_d      = 1'b0;
      grp_d      = grp_q;
      lnk_d      = lnk_q;
      if (wr_en) begin
         if (req_i.addr == rcb_pkg::OFS_HOST_ID) begin
            host_id_d = wd[15:0];
         end else if (req_i.addr == rcb_pkg::OFS_LABEL) begin
            label_d = wd;
         end else if (req_i.addr == rcb_pkg::OFS_RT_SEL) begin
            sel_id_d  = wd[7:0];
            sel_hi_d  = wd[15:8];
            sel_ext_d = wd[rcb_pkg::EXT_EN_BIT];
         end else if (req_i.addr == rcb_pkg::OFS_RT_PORT) begin
            rt_port_d = wd;
            upd_d     = 1'b1;                      // four entries from selected ID
         end else if (req_i.addr == rcb_pkg::OFS_RT_DEF) begin
            def_port_d = wd[7:0];
         end else if (req_i.addr == rcb_pkg::OFS_GRP_EDIT) begin
            grp_cmd_d  = wd[6:4];
            grp_port_d = wd[15:8];
            grp_sel_d  = wd[31:16];
            if (g_ok) begin
               case (wd[6:4])
                  rcb_pkg::GRP_VERIFY: begin
                     grp_hit_d = p_ok && grp_q[g_idx][wd[11:8]];
                  end
                  rcb_pkg::GRP_ADD: begin
                     if (p_ok) begin
                        grp_d[g_idx][wd[11:8]] = 1'b1;
                     end
                  end
                  rcb_pkg::GRP_DEL: begin
                     if (p_ok) begin
                        grp_d[g_idx][wd[11:8]] = 1'b0;
                     end
                  end
                  rcb_pkg::GRP_DEL_ALL: begin
                     grp_d[g_idx] = '0;
                  end
                  rcb_pkg::GRP_ADD_ALL: begin
                     for (int p = 0; p < rcb_pkg::PORTS; p++) begin
                        grp_d[g_idx][p] = (8'(p) < PORT_TOTAL);
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (wd[6:4] == rcb_pkg::GRP_VERIFY) begin
               grp_hit_d = 1'b0;                   // absent mask never hits
            end
         end else if (req_i.addr == rcb_pkg::OFS_LNK_SEL) begin
            lnk_sel_d = wd;
         end else if (req_i.addr == rcb_pkg::OFS_LNK_OP) begin
            lnk_cmd_d  = wd[6:5];
            lnk_wide_d = wd[rcb_pkg::LNK_WIDE_BIT];
            case (wd[6:5])
               rcb_pkg::LNK_VERIFY: begin
                  lnk_hit_d = l_ok && l_id_ok && lnk_q[l_id][l_idx];
               end
               rcb_pkg::LNK_DEL: begin
                  if (l_ok && l_id_ok) begin
                     lnk_d[l_id][l_idx] = 1'b0;
                  end
               end
               rcb_pkg::LNK_ADD: begin
                  if (l_ok && l_id_ok) begin
                     lnk_d[l_id][l_idx] = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end else if (req_i.addr == rcb_pkg::OFS_TIMEOUT) begin
            timeout_d = wd[31:rcb_pkg::TO_LSB];
         end
      end
   end

   // Read answer
   always_comb begin
      rsp_vld_d = req_valid_i;
      rsp_dat_d = rcb_pkg::WORD_RST;               // unmapped reads zero
      if (rd_en) begin
         if (req_i.addr == rcb_pkg::OFS_FEATURE) begin
            rsp_dat_d = feature_word();
         end else if (req_i.addr == rcb_pkg::OFS_PORT_INFO) begin
            rsp_dat_d[15:8] = PORT_TOTAL;
            rsp_dat_d[7:0]  = req_i.via_i2c ? rcb_pkg::I2C_PORT_CODE
                                            : req_i.src_port;
         end else if (req_i.addr == rcb_pkg::OFS_SRC_OPS) begin
            rsp_dat_d = src_ops_word();
         end else if (req_i.addr == rcb_pkg::OFS_MC_SUP) begin
            rsp_dat_d = rcb_pkg::MC_SUP_VALUE;
         end else if (req_i.addr == rcb_pkg::OFS_RT_LIMIT) begin
            rsp_dat_d[15:0] = rcb_pkg::RT_LIMIT_VAL;
         end else if (req_i.addr == rcb_pkg::OFS_MC_INFO) begin
            rsp_dat_d = {2'b00, rcb_pkg::MC_IDS_PER, rcb_pkg::MC_MASK_CNT};
         end else if (req_i.addr == rcb_pkg::OFS_HOST_ID) begin
            rsp_dat_d[15:0] = host_id_q;
         end else if (req_i.addr == rcb_pkg::OFS_LABEL) begin
            rsp_dat_d = label_q;
         end else if (req_i.addr == rcb_pkg::OFS_RT_SEL) begin
            rsp_dat_d = {sel_ext_q, 15'h0000, sel_hi_q, sel_id_q};
         end else if (req_i.addr == rcb_pkg::OFS_RT_PORT) begin
            rsp_dat_d = rt_port_q;
         end else if (req_i.addr == rcb_pkg::OFS_RT_DEF) begin
            rsp_dat_d[7:0] = def_port_q;
         end else if (req_i.addr == rcb_pkg::OFS_GRP_EDIT) begin
            rsp_dat_d = {grp_sel_q, grp_port_q, 1'b0, grp_cmd_q, 3'h0, grp_hit_q};
         end else if (req_i.addr == rcb_pkg::OFS_LNK_SEL) begin
            rsp_dat_d = lnk_sel_q;
         end else if (req_i.addr == rcb_pkg::OFS_LNK_OP) begin
            rsp_dat_d[7:0] = {lnk_wide_q, lnk_cmd_q, 4'h0, lnk_hit_q};
         end else if (req_i.addr == rcb_pkg::OFS_BLK_HEAD) begin
            rsp_dat_d = {rcb_pkg::BLK_NEXT_PTR, rcb_pkg::BLK_FEAT_ID};
         end else if (req_i.addr == rcb_pkg::OFS_TIMEOUT) begin
            rsp_dat_d = {timeout_q, 8'h00};
         end
      end
   end

   // Register everything on the core clock
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         host_id_q  <= rcb_pkg::HOST_ID_RST;
         label_q    <= rcb_pkg::WORD_RST;
         sel_id_q   <= 8'h00;
         sel_hi_q   <= 8'h00;
         sel_ext_q  <= 1'b0;
         rt_port_q  <= rcb_pkg::WORD_RST;
         def_port_q <= 8'h00;
         grp_cmd_q  <= 3'h0;
         grp_port_q <= 8'h00;
         grp_sel_q  <= 16'h0000;
         grp_hit_q  <= 1'b0;
         lnk_sel_q  <= rcb_pkg::WORD_RST;
         lnk_cmd_q  <= 2'h0;
         lnk_wide_q <= 1'b0;
         lnk_hit_q  <= 1'b0;
         timeout_q  <= rcb_pkg::TIMEOUT_RST;
         rsp_vld_q  <= 1'b0;
         rsp_dat_q  <= rcb_pkg::WORD_RST;
         upd_q      <= 1'b0;
         grp_q      <= '{default: '0};
         lnk_q      <= '{default: '0};
      end else begin
         host_id_q  <= host_id_d;
         label_q    <= label_d;
         sel_id_q   <= sel_id_d;
         sel_hi_q   <= sel_hi_d;
         sel_ext_q  <= sel_ext_d;
         rt_port_q  <= rt_port_d;
         def_port_q <= def_port_d;
         grp_cmd_q  <= grp_cmd_d;
         grp_port_q <= grp_port_d;
         grp_sel_q  <= grp_sel_d;
         grp_hit_q  <= grp_hit_d;
         lnk_sel_q  <= lnk_sel_d;
         lnk_cmd_q  <= lnk_cmd_d;
         lnk_wide_q <= lnk_wide_d;
         lnk_hit_q  <= lnk_hit_d;
         timeout_q  <= timeout_d;
         rsp_vld_q  <= rsp_vld_d;
         rsp_dat_q  <= rsp_dat_d;
         upd_q      <= upd_d;
         grp_q      <= grp_d;
         lnk_q      <= lnk_d;
      end
   end

   // Group membership out to the forwarding logic
   for (genvar g = 0; g < rcb_pkg::GROUPS; g++) begin : g_grp
      assign group_ports_o[g*rcb_pkg::PORTS +: rcb_pkg::PORTS] = grp_q[g];
   end

   assign rsp_valid_o          = rsp_vld_q;
   assign rsp_data_o           = rsp_dat_q;
   assign route_upd_o          = upd_q;
   assign route_o.ext_en       = sel_ext_q;
   assign route_o.wide_id_high = sel_hi_q;
   assign route_o.target_id    = sel_id_q;
   assign route_o.egress       = rt_port_q;
   assign default_port_o       = def_port_q;
   assign link_timeout_o       = timeout_q;
   assign initializer_id_o     = host_id_q;

endmodule : rcb_csr_bank
`default_nettype wire

// >>> tb/rcb_csr_bank_props.sv
// Purpose: Port checker for the switch capability and CSR bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound onto every instance of the bank.
`timescale 1ns/1ps
`default_nettype none
module rcb_csr_bank_props #(
   parameter logic [7:0] PORT_TOTAL = 8'h10
) (
   input wire logic                                     clk_i,
   input wire logic                                     rst_n_i,
   input wire logic                                     req_valid_i,
   input wire rcb_pkg::rcb_req_s                        req_i,
   input wire logic                                     rsp_valid_o,
   input wire logic [31:0]                              rsp_data_o,
   input wire logic                                     route_upd_o,
   input wire rcb_pkg::rcb_route_s                      route_o,
   input wire logic [7:0]                               default_port_o,
   input wire logic [23:0]                              link_timeout_o,
   input wire logic [15:0]                              initializer_id_o,
   input wire logic [rcb_pkg::PORTS*rcb_pkg::GROUPS-1:0] group_ports_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Access strobes and the mask bit a group command names
   wire logic       rd      = req_valid_i & ~req_i.wr;
   wire logic       wr      = req_valid_i & req_i.wr;
   wire logic [7:0] grp_bit = {req_i.wdata[19:16], 4'h0} + {4'h0, req_i.wdata[11:8]};

   rsp_follow_a: assert property (req_valid_i |=> rsp_valid_o)
      else $error("answer missing one cycle after a request");
   rsp_cause_a: assert property (rsp_valid_o |-> $past(req_valid_i))
      else $error("answer without a request");
   feature_bits_a: assert property (rd && req_i.addr == 24'h000010 |=>
      rsp_data_o[10:8] == 3'h7 && rsp_data_o[31:28] == 4'h1)
      else $error("feature word bits wrong");
   port_info_a: assert property (rd && req_i.addr == 24'h000014 |=>
      rsp_data_o == {16'h0000, PORT_TOTAL,
      ($past(req_i.via_i2c) ? 8'hFE : $past(req_i.src_port))})
      else $error("port info word wrong");
   src_ops_a: assert property (rd && req_i.addr == 24'h000018 |=>
      rsp_data_o == 32'h00000004) else $error("source ops word wrong");
   mc_info_a: assert property (rd && req_i.addr == 24'h000038 |=>
      rsp_data_o == 32'h00FF000A) else $error("multicast info word wrong");
   route_upd_a: assert property (wr && req_i.addr == 24'h000074 |=>
      route_upd_o && route_o.egress == $past(req_i.wdata))
      else $error("route update missing or wrong");
   host_id_a: assert property (wr && req_i.addr == 24'h000068 |=>
      initializer_id_o == $past(req_i.wdata[15:0])) else $error("initializer id not written");
   timeout_wr_a: assert property (wr && req_i.addr == 24'h000120 |=>
      link_timeout_o == $past(req_i.wdata[31:8])) else $error("timeout not written");
   reset_vals_a: assert property ($rose(rst_n_i) |->
      initializer_id_o == 16'hFFFF && link_timeout_o == 24'hFFFFFF)
      else $error("reset values wrong");
   group_add_a: assert property (wr && req_i.addr == 24'h000080 &&
      req_i.wdata[6:4] == 3'h1 && req_i.wdata[31:16] < 16'h000A &&
      req_i.wdata[15:8] < PORT_TOTAL |=> group_ports_o[$past(grp_bit)])
      else $error("group add did not set the port");
endmodule : rcb_csr_bank_props
bind rcb_csr_bank rcb_csr_bank_props #(.PORT_TOTAL(PORT_TOTAL)) u_rcb_csr_bank_props (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
   .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .route_upd_o(route_upd_o),
   .route_o(route_o), .default_port_o(default_port_o), .link_timeout_o(link_timeout_o),
   .initializer_id_o(initializer_id_o), .group_ports_o(group_ports_o));
`default_nettype wire

// >>> tb/rcb_host_model.sv
// Purpose: Maintenance host that issues single accesses to the bank.
// Assumes: Request taken on the edge after it is driven.
// Notes:   Idle request lines show the inverse of the last access.
`timescale 1ns/1ps
`default_nettype none
module rcb_host_model (
   input wire logic               clk_i,
   input wire logic               rsp_valid_i,
   input wire logic [31:0]        rsp_data_i,
   output logic                   req_valid_o,
   output rcb_pkg::rcb_req_s      req_o
);
   logic rsp_ok;
   // Idle at time zero
   initial begin
      req_valid_o = 1'b0;
      req_o = '0;
   end
   // One access: drive, release at the taking edge, sample the answer after it
   task automatic access(input logic w, input logic [23:0] a, input logic [31:0] d,
                         input logic [7:0] p, input logic i2c, output logic [31:0] r);
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_o <= '{wr: w, addr: a, wdata: d, src_port: p, via_i2c: i2c};
      @(posedge clk_i);
      req_valid_o <= 1'b0;
      req_o <= rcb_pkg::rcb_req_s'(~req_o);
      #1;
      rsp_ok = rsp_valid_i;
      r = rsp_data_i;
   endtask : access
endmodule : rcb_host_model
`default_nettype wire

// >>> tb/rcb_csr_bank_tb_top.sv
// Purpose: Self-checking bench for the switch capability and CSR bank.
// Assumes: Sixteen-port variant.
// Notes:   All accesses go through the host model.
`timescale 1ns/1ps
`default_nettype none
module rcb_csr_bank_tb_top;
   logic clk_i, rst_n_i, req_valid_i, rsp_valid_o, route_upd_o, via_i2c;
   rcb_pkg::rcb_req_s   req_i;
   rcb_pkg::rcb_route_s route_o;
   logic [31:0]  rsp_data_o, r;
   logic [7:0]   default_port_o, src_port;
   logic [23:0]  link_timeout_o;
   logic [15:0]  initializer_id_o;
   logic [159:0] group_ports_o;
   int fails, check_count, cycles;
   localparam logic [31:0] P = 32'hA5C35A3C;

   rcb_csr_bank u_rcb_csr_bank (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .route_upd_o(route_upd_o), .route_o(route_o),
      .default_port_o(default_port_o), .link_timeout_o(link_timeout_o),
      .initializer_id_o(initializer_id_o), .group_ports_o(group_ports_o));
   rcb_host_model u_rcb_host_model (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o),
      .rsp_data_i(rsp_data_o), .req_valid_o(req_valid_i), .req_o(req_i));

   // Clock and run-length guard
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         summarize();
      end
   end
   // Compare one value
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One access; every request is answered, writes with zero data
   task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d);
      u_rcb_host_model.access(w, a, d, src_port, via_i2c, r);
      chk({31'h0, u_rcb_host_model.rsp_ok}, 32'h1);
      if (w) chk(r, 32'h0);
   endtask : acc
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd_chk(input logic [23:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(r, e);
   endtask : rd_chk
   // Fixed capability words, arrival port and unmapped space
   task automatic t_caps();
      rd_chk(24'h000010, 32'h10000759);
      rd_chk(24'h000014, 32'h00001003);
      src_port = 8'h0F;
      rd_chk(24'h000014, 32'h0000100F);
      via_i2c = 1'b1;
      rd_chk(24'h000014, 32'h000010FE);
      via_i2c = 1'b0;
      rd_chk(24'h000018, 32'h00000004);
      rd_chk(24'h000030, 32'h00000000);
      rd_chk(24'h000034, 32'h000000FF);
      rd_chk(24'h000038, 32'h00FF000A);
      rd_chk(24'h000100, 32'h00000009);
      rd_chk(24'h00013C, 32'h00000000);
      rd_chk(24'h0001F0, 32'h00000000);
   endtask : t_caps
   // Reset values of four writable words and of the timeout and default port outputs
   task automatic t_resets();
      rd_chk(24'h000068, 32'h0000FFFF);
      rd_chk(24'h00006C, 32'h00000000);
      rd_chk(24'h000078, 32'h00000000);
      rd_chk(24'h000120, 32'hFFFFFF00);
      chk({8'h0, link_timeout_o}, 32'h00FFFFFF);
      chk({24'h0, default_port_o}, 32'h0);
   endtask : t_resets
   // Writes with an idle cycle between, reserved bits dropped, read-only word unchanged
   task automatic t_rw();
      wr(24'h000068, P);
      chk({16'h0, initializer_id_o}, 32'h00005A3C);
      wr(24'h00006C, P);
      wr(24'h000070, P);
      chk({7'h0, route_o.ext_en, route_o.wide_id_high, route_o.target_id}, 32'h00015A3C);
      wr(24'h000074, P);
      chk(route_o.egress, P);
      chk({31'h0, route_upd_o}, 32'h1);
      wr(24'h000078, P);
      chk({31'h0, route_upd_o}, 32'h0);
      wr(24'h000084, P);
      wr(24'h000120, P);
      wr(24'h000010, 32'hFFFFFFFF);
      rd_chk(24'h000068, 32'h00005A3C);
      rd_chk(24'h00006C, P);
      rd_chk(24'h000070, 32'h80005A3C);
      rd_chk(24'h000074, P);
      rd_chk(24'h000078, 32'h0000003C);
      rd_chk(24'h000084, P);
      rd_chk(24'h000120, 32'hA5C35A00);
      rd_chk(24'h000010, 32'h10000759);
      chk({24'h0, default_port_o}, 32'h3C);
   endtask : t_rw
   // Every group edit command, verify result and an out-of-range mask
   task automatic t_group();
      wr(24'h000080, 32'h00020310);
      chk({31'h0, group_ports_o[35]}, 32'h1);
      wr(24'h000080, 32'h00021010);
      chk({31'h0, group_ports_o[32]}, 32'h0);
      wr(24'h000080, 32'h00021300);
      rd_chk(24'h000080, 32'h00021300);
      wr(24'h000080, 32'h00020300);
      rd_chk(24'h000080, 32'h00020301);
      wr(24'h000080, 32'h00020320);
      chk({31'h0, group_ports_o[35]}, 32'h0);
      wr(24'h000080, 32'h00020300);
      rd_chk(24'h000080, 32'h00020300);
      wr(24'h000080, 32'h00090050);
      chk({16'h0, group_ports_o[159:144]}, 32'h0000FFFF);
      wr(24'h000080, 32'h00090040);
      wr(24'h000080, 32'h000A0310);
      chk({31'h0, |group_ports_o}, 32'h0);
   endtask : t_group
   // Association add, verify, delete, and a refused large transport
   task automatic t_link();
      wr(24'h000084, 32'h00050002);
      wr(24'h000088, 32'h00000060);
      wr(24'h000088, 32'h00000000);
      rd_chk(24'h000088, 32'h00000001);
      wr(24'h000088, 32'h00000020);
      wr(24'h000088, 32'h00000000);
      rd_chk(24'h000088, 32'h00000000);
      wr(24'h000088, 32'h00000060);
      wr(24'h000084, 32'h01050002);
      wr(24'h000088, 32'h00000080);
      rd_chk(24'h000088, 32'h00000080);
      wr(24'h000084, 32'h00050002);
      wr(24'h000088, 32'h00000080);
      rd_chk(24'h000088, 32'h00000081);
   endtask : t_link
   // Counts and verdict
   task automatic summarize();
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // Main sequence, with a second reset mid-run
   initial begin
      rst_n_i = 1'b0;
      src_port = 8'h03;
      via_i2c = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_caps();
      t_resets();
      t_rw();
      t_group();
      t_link();
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_resets();
      rd_chk(24'h000084, 32'h00000000);
      summarize();
   end
endmodule : rcb_csr_bank_tb_top
`default_nettype wire
